// ==== shared/bus_seq_pkg.sv ====
// Constants and types for the bus machine-cycle sequencer
// Assumes a single processor clock, one T-state per clock
`default_nettype none
package bus_seq_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Internal idle states per instruction class
  localparam logic [2:0] IDLE_REG_ALU = 3'h1;
  localparam logic [2:0] IDLE_PAIR_ALU = 3'h4;
  localparam logic [2:0] IDLE_INDEXED = 3'h3;
  // T-states in a bus cycle
  localparam logic [1:0] BUS_STATES = 2'h3;
  localparam logic [ADDR_W-1:0] PC_RESET = 16'h0000;
  // Instruction classes handed in by the decoder
  typedef enum logic [2:0] {
    CLS_REG_ALU,
    CLS_PAIR_ALU,
    CLS_IMM_ALU,
    CLS_PTR_ALU,
    CLS_IDX_ALU,
    CLS_IDX_BIT,
    CLS_BIT_REG,
    CLS_BIT_PTR
  } instr_class_t;
  // Machine cycle kinds
  typedef enum {
    CYC_FETCH1,
    CYC_FETCH2,
    CYC_DISP,
    CYC_FETCH3,
    CYC_OPERAND,
    CYC_DATA,
    CYC_IDLE
  } cycle_t;
endpackage
`default_nettype wire

// ==== hdl/bus_cycle_sequencer.sv ====
// Machine-cycle sequencer for the external processor bus
// Assumes the decoder gives the instruction class and prefix flag during fetches
// Behaviour
// - First cycle: three-state opcode fetch, read, memory, fetch low, status low.
// - Prefixed instructions fetch second opcode byte likewise, status driven high.
// - Idle states: address invalid, data floating, all strobes and status high.
// - Immediate or pointer-indirect ALU ops read one operand after the fetch.
// - Indexed ALU: two fetches, displacement, idle states, data read at index+d.
// - Indexed bit test: two fetches, displacement, third fetch, then data read.
`default_nettype none
module bus_cycle_sequencer
  import bus_seq_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  // Decoder
  input wire logic [2:0] CLASS_IN,
  input wire logic PREFIX_IN,
  input wire logic USE_Y_IN,
  input wire logic [ADDR_W-1:0] POINTER_PAIR_IN,
  input wire logic [ADDR_W-1:0] INDEX_REG_X_IN,
  input wire logic [ADDR_W-1:0] INDEX_REG_Y_IN,
  // Data bus
  input wire logic [DATA_W-1:0] DATA_IN,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic DATA_OE_N_OUT,
  // Address and strobes
  output logic [ADDR_W-1:0] ADDRESS_OUT,
  output logic ADDRESS_VALID_OUT,
  output logic READ_STROBE_N_OUT,
  output logic WRITE_STROBE_N_OUT,
  output logic MEMORY_REQUEST_N_OUT,
  output logic IO_REQUEST_N_OUT,
  output logic FETCH_CYCLE_N_OUT,
  output logic HALTED_N_OUT,
  output logic STATUS_OUT,
  // Timing
  output logic CYCLE_END_OUT
);
  cycle_t cycle;
  cycle_t next_cycle;
  instr_class_t cls;
  logic [1:0] t_state;
  logic [2:0] idle_left;
  logic [ADDR_W-1:0] pc;
  logic [DATA_W-1:0] disp;
  logic is_bus;
  logic last_state;
  logic is_fetch;
  logic [ADDR_W-1:0] index_base;
  logic [ADDR_W-1:0] bus_addr;
  instr_class_t eff_cls;
  logic [1:0] next_t_state;
  logic [2:0] next_idle_left;
  logic [ADDR_W-1:0] next_pc;
  logic [ADDR_W-1:0] next_address;
  logic next_valid;
  logic next_read_n;
  logic next_memory_request_n_n;
  logic next_fetch_n;
  logic next_status;
  logic uses_pointer;
  logic uses_index;
  logic load_idle;
  logic take_class;
  logic take_disp;
  logic step_pc;

  // Sign-extended displacement added to an index base
  function automatic logic [ADDR_W-1:0] add_disp(input logic [ADDR_W-1:0] b, input logic [DATA_W-1:0] d);
    add_disp = b + {{(ADDR_W-DATA_W){d[DATA_W-1]}}, d};
  endfunction

  // Classes whose data read goes to the pointer pair
  function automatic logic is_ptr_class(input instr_class_t c);
    is_ptr_class = (c == CLS_PTR_ALU) || (c == CLS_BIT_PTR);
  endfunction

  // Classes whose data read goes to index plus displacement
  function automatic logic is_idx_class(input instr_class_t c);
    is_idx_class = (c == CLS_IDX_ALU) || (c == CLS_IDX_BIT);
  endfunction

  // Number of idle states a class inserts
  function automatic logic [2:0] idle_count(input instr_class_t c);
    if (c == CLS_PAIR_ALU) begin
      idle_count = IDLE_PAIR_ALU;
    end else if (c == CLS_IDX_ALU) begin
      idle_count = IDLE_INDEXED;
    end else begin
      idle_count = IDLE_REG_ALU;
    end
  endfunction

  // Cycle decoding
  assign is_bus = (cycle != CYC_IDLE);
  assign is_fetch = (cycle == CYC_FETCH1) || (cycle == CYC_FETCH2) || (cycle == CYC_FETCH3);
  assign last_state = is_bus ? (t_state == BUS_STATES - 2'h1) : (idle_left == 3'h1);
  assign eff_cls = (cycle == CYC_FETCH1) ? instr_class_t'(CLASS_IN) : cls;
  assign index_base = USE_Y_IN ? INDEX_REG_Y_IN : INDEX_REG_X_IN;

  // Address selection
  assign uses_pointer = (cycle == CYC_DATA) && is_ptr_class(cls);
  assign uses_index = (cycle == CYC_DATA) && is_idx_class(cls);
  assign bus_addr = uses_pointer ? POINTER_PAIR_IN
                  : uses_index ? add_disp(index_base, disp) : pc;

  // Next values of counters and captured fields
  assign next_t_state = (is_bus && !last_state) ? t_state + 2'h1 : 2'h0;
  assign load_idle = last_state && (next_cycle == CYC_IDLE);
  assign next_idle_left = load_idle ? idle_count(eff_cls)
                        : (!is_bus && !last_state) ? idle_left - 3'h1 : idle_left;
  assign take_class = (cycle == CYC_FETCH1) && last_state;
  assign take_disp = (cycle == CYC_DISP) && last_state;
  assign step_pc = is_bus && last_state && (cycle != CYC_DATA);
  assign next_pc = step_pc ? pc + 16'h1 : pc;

  // Bus outputs for the cycle now running
  assign next_address = bus_addr;
  assign next_valid = is_bus;
  assign next_read_n = !is_bus;
  assign next_memory_request_n_n = !is_bus;
  assign next_fetch_n = !is_fetch;
  assign next_status = (cycle != CYC_FETCH1);

  // Cycle selection after the last state of a cycle
  always_comb begin
    next_cycle = CYC_FETCH1;
    unique case (cycle)
      CYC_FETCH1: begin
        if (PREFIX_IN) next_cycle = CYC_FETCH2;
        else if (eff_cls == CLS_REG_ALU || eff_cls == CLS_PAIR_ALU) next_cycle = CYC_IDLE;
        else if (eff_cls == CLS_IMM_ALU) next_cycle = CYC_OPERAND;
        else if (eff_cls == CLS_PTR_ALU) next_cycle = CYC_DATA;
      end
      CYC_FETCH2: begin
        if (cls == CLS_IDX_ALU || cls == CLS_IDX_BIT) next_cycle = CYC_DISP;
        else if (cls == CLS_PAIR_ALU) next_cycle = CYC_IDLE;
        else if (cls == CLS_BIT_PTR || cls == CLS_PTR_ALU) next_cycle = CYC_DATA;
      end
      CYC_DISP: next_cycle = (cls == CLS_IDX_BIT) ? CYC_FETCH3 : CYC_IDLE;
      CYC_FETCH3: next_cycle = CYC_DATA;
      CYC_IDLE: next_cycle = (cls == CLS_IDX_ALU) ? CYC_DATA : CYC_FETCH1;
      CYC_OPERAND: next_cycle = CYC_FETCH1;
      CYC_DATA: next_cycle = CYC_FETCH1;
    endcase
  end

  // Machine cycle and T-state
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      cycle <= CYC_FETCH1;
      t_state <= 2'h0;
    end else begin
      if (last_state) cycle <= next_cycle;
      t_state <= next_t_state;
    end
  end

  // Idle state counter
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      idle_left <= 3'h0;
    end else begin
      idle_left <= next_idle_left;
    end
  end

  // Class captured at the end of the first fetch
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      cls <= CLS_REG_ALU;
    end else if (take_class) begin
      cls <= eff_cls;
    end
  end

  // Opcode and operand address counter
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      pc <= PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // Displacement taken at the end of its read
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      disp <= '0;
    end else if (take_disp) begin
      disp <= DATA_IN;
    end
  end

  // Bus outputs registered, idle states float the bus
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      ADDRESS_OUT <= '0;
      ADDRESS_VALID_OUT <= 1'b0;
      READ_STROBE_N_OUT <= 1'b1;
      MEMORY_REQUEST_N_OUT <= 1'b1;
      FETCH_CYCLE_N_OUT <= 1'b1;
      STATUS_OUT <= 1'b1;
    end else begin
      ADDRESS_OUT <= next_address;
      ADDRESS_VALID_OUT <= next_valid;
      READ_STROBE_N_OUT <= next_read_n;
      MEMORY_REQUEST_N_OUT <= next_memory_request_n_n;
      FETCH_CYCLE_N_OUT <= next_fetch_n;
      STATUS_OUT <= next_status;
    end
  end

  // Only read cycles here: never writes, no I/O, never halted
  assign WRITE_STROBE_N_OUT = 1'b1;
  assign IO_REQUEST_N_OUT = 1'b1;
  assign HALTED_N_OUT = 1'b1;
  assign DATA_OUT = '0;
  assign DATA_OE_N_OUT = 1'b1;
  assign CYCLE_END_OUT = last_state;
endmodule
`default_nettype wire

// ==== bench/bus_seq_asserts.sv ====
// Output assertions for the bus cycle sequencer
// Bound to the sequencer top, sees its ports only
`default_nettype none
module bus_seq_asserts (
  input wire logic SYS_CLK_IN, RESET_IN, STATUS_OUT, CYCLE_END_OUT, ADDRESS_VALID_OUT,
  input wire logic READ_STROBE_N_OUT, MEMORY_REQUEST_N_OUT, FETCH_CYCLE_N_OUT,
  input wire logic [15:0] ADDRESS_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  wire logic rd = !READ_STROBE_N_OUT && !MEMORY_REQUEST_N_OUT;
  wire logic fe = !FETCH_CYCLE_N_OUT;
  property p_f1; $fell(STATUS_OUT) |-> (rd && fe) [*3] ##1 STATUS_OUT; endproperty
  a_f1: assert property (p_f1) else $error("fetch1");
  property p_f2; fe && STATUS_OUT |-> rd; endproperty
  a_f2: assert property (p_f2) else $error("fetch2");
  property p_ti; !ADDRESS_VALID_OUT |-> !fe && STATUS_OUT && READ_STROBE_N_OUT && MEMORY_REQUEST_N_OUT; endproperty
  a_ti: assert property (p_ti) else $error("idle");
  property p_rd; ADDRESS_VALID_OUT && !fe |-> rd && STATUS_OUT; endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_ix; $fell(ADDRESS_VALID_OUT) |-> ##[1:4] ADDRESS_VALID_OUT; endproperty
  a_ix: assert property (p_ix) else $error("idles");
  property p_bt; $rose(fe) && STATUS_OUT |-> ##3 !fe && rd ##3 !STATUS_OUT; endproperty
  a_bt: assert property (p_bt) else $error("fetch3");
  property p_cy; $rose(ADDRESS_VALID_OUT) |-> ##1 CYCLE_END_OUT && $stable(ADDRESS_OUT) ##1 $stable(ADDRESS_OUT); endproperty
  a_cy: assert property (p_cy) else $error("states");
  c_ti4: cover property (!ADDRESS_VALID_OUT [*4]);
  c_f3: cover property ($rose(fe) && STATUS_OUT);
  c_f2: cover property (fe && STATUS_OUT);
endmodule
bind bus_cycle_sequencer bus_seq_asserts bus_seq_asserts_i (.*);
`default_nettype wire

// ==== bench/bus_mem_model.sv ====
// Memory on the far side of the bus
// Answers a read with the address low byte, bit 7 inverted
`default_nettype none
module bus_mem_model (
  input wire logic SYS_CLK_IN, READ_STROBE_N_OUT, MEMORY_REQUEST_N_OUT,
  input wire logic [15:0] ADDRESS_OUT,
  output var logic [7:0] DATA_IN = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released bus toggles so stale data never passes for a read
  always @(posedge SYS_CLK_IN) begin
    DATA_IN <= (!READ_STROBE_N_OUT && !MEMORY_REQUEST_N_OUT) ? ADDRESS_OUT[7:0] ^ 8'h80 : ~DATA_IN;
  end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Bench for the bus cycle sequencer
// Assumes the memory model on the bus
`default_nettype none
module tb_top import bus_seq_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic SYS_CLK_IN = 0, RESET_IN = 1, PREFIX_IN = 0, USE_Y_IN = 0;
  logic [2:0] CLASS_IN = 3'h0;
  logic [15:0] POINTER_PAIR_IN = 16'h1234, INDEX_REG_X_IN = 16'h4000, INDEX_REG_Y_IN = 16'h8000, pc = 16'h0, a;
  logic [15:0] ADDRESS_OUT;
  logic [7:0] DATA_IN, DATA_OUT;
  logic DATA_OE_N_OUT, ADDRESS_VALID_OUT, READ_STROBE_N_OUT, WRITE_STROBE_N_OUT, MEMORY_REQUEST_N_OUT;
  logic IO_REQUEST_N_OUT, FETCH_CYCLE_N_OUT, HALTED_N_OUT, STATUS_OUT, CYCLE_END_OUT;
  int errors = 0, n_checks = 0, cycles = 0;
  bus_cycle_sequencer bus_cycle_sequencer_i (.*);
  bus_mem_model bus_mem_model_i (.*);
  initial forever #10 SYS_CLK_IN = ~SYS_CLK_IN;
  always @(posedge SYS_CLK_IN) if (++cycles > 300) begin errors++; final_report(); end
  task final_report;
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [24:0] g, e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [8:0] v();
    return {ADDRESS_VALID_OUT, READ_STROBE_N_OUT, MEMORY_REQUEST_N_OUT, FETCH_CYCLE_N_OUT, STATUS_OUT,
      WRITE_STROBE_N_OUT, IO_REQUEST_N_OUT, HALTED_N_OUT, DATA_OE_N_OUT};
  endfunction
  // Bus cycle: three clocks checked at falling edges
  // Decoder inputs, when asked, are driven at the first rising edge of the cycle
  task b(input logic f, s, input logic [15:0] ad, input logic ld = 1'h0, y = 1'h0, input logic [2:0] c = 3'h0,
    input logic p = 1'h0);
    repeat (3) begin
      chk({v(), ADDRESS_OUT}, {3'h4, f, s, 4'hf, ad});
      @(posedge SYS_CLK_IN);
      if (ld) begin
        CLASS_IN <= c;
        PREFIX_IN <= p;
        USE_Y_IN <= y;
        ld = 1'h0;
      end
      @(negedge SYS_CLK_IN);
    end
  endtask
  task i(input int n);
    repeat (n) begin
      chk({v(), 16'h0}, {9'h0ff, 16'h0});
      chk({17'h0, DATA_OUT}, 25'h0);
      @(negedge SYS_CLK_IN);
    end
  endtask
  task op(input logic f); b(f, 1'h1, pc); pc++; endtask
  task f1(input logic [2:0] c, input logic p, input logic y = 1'h0); b(1'h0, 1'h0, pc, 1'h1, y, c, p); pc++; endtask
  function automatic logic [15:0] dsp(input logic [15:0] r); return r + {{8{~pc[7]}}, pc[7:0] ^ 8'h80}; endfunction
  task t_reg; f1(CLS_REG_ALU, 1'h0); i(1); endtask
  task t_pair; f1(CLS_PAIR_ALU, 1'h1); op(1'h0); i(4); f1(CLS_PAIR_ALU, 1'h0); i(4); endtask
  task t_imm; f1(CLS_IMM_ALU, 1'h0); op(1'h1); endtask
  task t_ptr; f1(CLS_PTR_ALU, 1'h0); b(1'h1, 1'h1, POINTER_PAIR_IN); endtask
  task t_ixa;
    f1(CLS_IDX_ALU, 1'h1, 1'h1); op(1'h0); a = dsp(INDEX_REG_Y_IN); op(1'h1); i(3); b(1'h1, 1'h1, a);
  endtask
  task t_ixb;
    f1(CLS_IDX_BIT, 1'h1, 1'h0); op(1'h0); a = dsp(INDEX_REG_X_IN); op(1'h1); op(1'h0); b(1'h1, 1'h1, a);
  endtask
  task t_bit; f1(CLS_BIT_REG, 1'h1); op(1'h0); f1(CLS_BIT_PTR, 1'h1); op(1'h0); b(1'h1, 1'h1, POINTER_PAIR_IN); endtask
  initial begin
    repeat (12) @(posedge SYS_CLK_IN);
    RESET_IN <= 1'h0;
    while (ADDRESS_VALID_OUT !== 1'h1) @(negedge SYS_CLK_IN);
    t_reg;
    t_pair;
    t_imm;
    t_ptr;
    t_ixa;
    t_ixb;
    t_bit;
    final_report();
  end
endmodule
`default_nettype wire
